// ===== hw/vpu_top.sv
// vectored priority unit: sorts channel requests into fast, vectored and plain normal classes
// assumes request lines are on-chip levels on aclk, one per peripheral, already ORed
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module vpu_top #(
  parameter int NUM_CH = vpu_pkg::NUM_CH,
  parameter int NUM_SLOT = vpu_pkg::NUM_SLOT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_CH-1:0] src_request,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic fast_request,
  output logic normal_request
);

  localparam int SLOT_W = vpu_pkg::SLOT_W;
  localparam int CH_W = vpu_pkg::CH_W;

  // byte-lane merge shared by the writable registers except slot control
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return res;
  endfunction

  // is this byte address inside one of the two slot tables
  function automatic logic in_slot_page(input logic [11:0] addr, input logic [3:0] page);
    return (addr[11:8] == page) && (addr[7:6] == 2'b00) && (addr[1:0] == 2'b00);
  endfunction

  logic wr_go, wr_err, rd_go;
  logic [11:0] rd_addr;
  vpu_pkg::vpu_wr_type wr_cmd;
  vpu_pkg::vpu_rd_type rd_ans;

  vpu_axil_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_go(wr_go),
    .wr_cmd(wr_cmd),
    .wr_err(wr_err),
    .rd_go(rd_go),
    .rd_addr(rd_addr),
    .rd_ans(rd_ans)
  );

  // software state
  logic [NUM_CH-1:0] class_ff;
  logic [NUM_CH-1:0] enable_ff;
  logic [NUM_CH-1:0] soft_ff;
  logic [31:0] default_addr_ff;
  logic [31:0] slot_addr_ff [NUM_SLOT];
  logic [CH_W-1:0] slot_ch_ff [NUM_SLOT];
  logic slot_en_ff [NUM_SLOT];
  logic fast_request_ff, normal_request_ff;

  // request sorting
  logic [NUM_CH-1:0] hw_lines, raw_req, act_req, fast_act, normal_act;
  logic [NUM_CH-1:0] claimed, vect_act, plain_act;
  logic [NUM_SLOT-1:0] slot_hit;
  logic any_vect;
  logic [SLOT_W-1:0] win_slot;
  logic [31:0] vector_addr;

  // channel 1 has no hardware line, only the soft bit can raise it
  assign hw_lines = src_request & NUM_CH'(vpu_pkg::HW_LINE_MASK);
  assign raw_req = hw_lines | soft_ff;
  assign act_req = raw_req & enable_ff;
  assign fast_act = act_req & class_ff;
  assign normal_act = act_req & ~class_ff;

  // a fast channel never competes for a slot, so fast outranks vectored
  always_comb begin
    claimed = '0;
    for (int s = 0; s < NUM_SLOT; s++) begin
      slot_hit[s] = slot_en_ff[s] && normal_act[slot_ch_ff[s]];
      if (slot_en_ff[s]) begin
        claimed[slot_ch_ff[s]] = 1'b1;
      end
    end
  end

  assign vect_act = normal_act & claimed;
  assign plain_act = normal_act & ~claimed;

  vpu_slot_pick #(
    .NUM_SLOT(NUM_SLOT),
    .SLOT_W(SLOT_W)
  ) u_pick (
    .slot_hit(slot_hit),
    .any_hit(any_vect),
    .win_slot(win_slot)
  );

  // winner's address, else the shared default for non-vectored requests
  assign vector_addr = any_vect ? slot_addr_ff[win_slot] : default_addr_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_request_ff <= 1'b0;
      normal_request_ff <= 1'b0;
    end else begin
      fast_request_ff <= |fast_act;
      normal_request_ff <= |(vect_act | plain_act);
    end
  end

  // write decode; writes land any time, so priorities can move while running
  always_comb begin
    wr_err = 1'b0;
    if (wr_cmd.addr == vpu_pkg::OFS_CLASS_SELECT) begin
      wr_err = 1'b0;
    end else if (wr_cmd.addr == vpu_pkg::OFS_ENABLE_SET) begin
      wr_err = 1'b0;
    end else if (wr_cmd.addr == vpu_pkg::OFS_ENABLE_CLEAR) begin
      wr_err = 1'b0;
    end else if (wr_cmd.addr == vpu_pkg::OFS_SOFT_SET) begin
      wr_err = 1'b0;
    end else if (wr_cmd.addr == vpu_pkg::OFS_SOFT_CLEAR) begin
      wr_err = 1'b0;
    end else if (wr_cmd.addr == vpu_pkg::OFS_DEFAULT_ADDR) begin
      wr_err = 1'b0;
    end else if (in_slot_page(wr_cmd.addr, vpu_pkg::PAGE_SLOT_ADDR)) begin
      wr_err = 1'b0;
    end else if (in_slot_page(wr_cmd.addr, vpu_pkg::PAGE_SLOT_CTRL)) begin
      wr_err = 1'b0;
    end else if (wr_cmd.addr == vpu_pkg::OFS_VECTOR_ADDR) begin
      // accepted and dropped: the vector word is read-only state
      wr_err = 1'b0;
    end else begin
      wr_err = 1'b1;
    end
  end

  logic [31:0] set_bits, clr_bits;
  assign set_bits = merge_lanes(32'h0000_0000, wr_cmd.data, wr_cmd.strb);
  assign clr_bits = set_bits;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      class_ff <= NUM_CH'(vpu_pkg::RST_WORD);
    end else if (wr_go && wr_cmd.addr == vpu_pkg::OFS_CLASS_SELECT) begin
      class_ff <= NUM_CH'(merge_lanes(32'(class_ff), wr_cmd.data, wr_cmd.strb));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_ff <= NUM_CH'(vpu_pkg::RST_WORD);
    end else if (wr_go && wr_cmd.addr == vpu_pkg::OFS_ENABLE_SET) begin
      enable_ff <= enable_ff | NUM_CH'(set_bits);
    end else if (wr_go && wr_cmd.addr == vpu_pkg::OFS_ENABLE_CLEAR) begin
      enable_ff <= enable_ff & ~NUM_CH'(clr_bits);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_ff <= NUM_CH'(vpu_pkg::RST_WORD);
    end else if (wr_go && wr_cmd.addr == vpu_pkg::OFS_SOFT_SET) begin
      soft_ff <= soft_ff | NUM_CH'(set_bits);
    end else if (wr_go && wr_cmd.addr == vpu_pkg::OFS_SOFT_CLEAR) begin
      soft_ff <= soft_ff & ~NUM_CH'(clr_bits);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      default_addr_ff <= vpu_pkg::RST_ADDR;
    end else if (wr_go && wr_cmd.addr == vpu_pkg::OFS_DEFAULT_ADDR) begin
      default_addr_ff <= merge_lanes(default_addr_ff, wr_cmd.data, wr_cmd.strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < NUM_SLOT; s++) begin
        slot_addr_ff[s] <= vpu_pkg::RST_ADDR;
      end
    end else if (wr_go && in_slot_page(wr_cmd.addr, vpu_pkg::PAGE_SLOT_ADDR)) begin
      slot_addr_ff[wr_cmd.addr[5:2]] <= merge_lanes(slot_addr_ff[wr_cmd.addr[5:2]],
                                                    wr_cmd.data, wr_cmd.strb);
    end
  end

  // slot control lives in byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < NUM_SLOT; s++) begin
        slot_ch_ff[s] <= vpu_pkg::RST_SLOT_CTRL[CH_W-1:0];
        slot_en_ff[s] <= vpu_pkg::RST_SLOT_CTRL[vpu_pkg::SLOT_EN_BIT];
      end
    end else if (wr_go && in_slot_page(wr_cmd.addr, vpu_pkg::PAGE_SLOT_CTRL)
                 && wr_cmd.strb[0]) begin
      slot_ch_ff[wr_cmd.addr[5:2]] <= wr_cmd.data[vpu_pkg::SLOT_CH_LSB +: CH_W];
      slot_en_ff[wr_cmd.addr[5:2]] <= wr_cmd.data[vpu_pkg::SLOT_EN_BIT];
    end
  end

  // read decode; reserved bits read zero, unmapped addresses answer with an error
  always_comb begin
    rd_ans.resp = vpu_pkg::RESP_OKAY;
    rd_ans.data = vpu_pkg::RST_WORD;
    if (rd_addr == vpu_pkg::OFS_NORMAL_STATUS) begin
      rd_ans.data = 32'(normal_act);
    end else if (rd_addr == vpu_pkg::OFS_FAST_STATUS) begin
      rd_ans.data = 32'(fast_act);
    end else if (rd_addr == vpu_pkg::OFS_RAW_STATUS) begin
      rd_ans.data = 32'(raw_req);
    end else if (rd_addr == vpu_pkg::OFS_CLASS_SELECT) begin
      rd_ans.data = 32'(class_ff);
    end else if (rd_addr == vpu_pkg::OFS_ENABLE_SET) begin
      rd_ans.data = 32'(enable_ff);
    end else if (rd_addr == vpu_pkg::OFS_ENABLE_CLEAR) begin
      rd_ans.data = 32'(enable_ff);
    end else if (rd_addr == vpu_pkg::OFS_SOFT_SET) begin
      rd_ans.data = 32'(soft_ff);
    end else if (rd_addr == vpu_pkg::OFS_SOFT_CLEAR) begin
      rd_ans.data = 32'(soft_ff);
    end else if (rd_addr == vpu_pkg::OFS_VECTOR_ADDR) begin
      rd_ans.data = vector_addr;
    end else if (rd_addr == vpu_pkg::OFS_DEFAULT_ADDR) begin
      rd_ans.data = default_addr_ff;
    end else if (rd_addr == vpu_pkg::OFS_SLOT_STATUS) begin
      rd_ans.data = 32'(slot_hit);
    end else if (in_slot_page(rd_addr, vpu_pkg::PAGE_SLOT_ADDR)) begin
      rd_ans.data = slot_addr_ff[rd_addr[5:2]];
    end else if (in_slot_page(rd_addr, vpu_pkg::PAGE_SLOT_CTRL)) begin
      rd_ans.data[vpu_pkg::SLOT_CH_LSB +: CH_W] = slot_ch_ff[rd_addr[5:2]];
      rd_ans.data[vpu_pkg::SLOT_EN_BIT] = slot_en_ff[rd_addr[5:2]];
    end else begin
      rd_ans.resp = vpu_pkg::RESP_SLVERR;
    end
  end

  assign fast_request = fast_request_ff;
  assign normal_request = normal_request_ff;

endmodule // vpu_top

// ===== hw/vpu_pkg.sv
// package for the vectored priority unit: register map, field layout, reset values, bus types
// assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address
package vpu_pkg;

  localparam int NUM_CH = 32;
  localparam int CH_W = 5;
  localparam int NUM_SLOT = 16;
  localparam int SLOT_W = 4;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // channels with a fixed meaning
  localparam int CH_WATCHDOG = 0;
  localparam int CH_SOFT_ONLY = 1;

  // register byte offsets
  localparam logic [11:0] OFS_NORMAL_STATUS = 12'h000;
  localparam logic [11:0] OFS_FAST_STATUS = 12'h004;
  localparam logic [11:0] OFS_RAW_STATUS = 12'h008;
  localparam logic [11:0] OFS_CLASS_SELECT = 12'h00c;
  localparam logic [11:0] OFS_ENABLE_SET = 12'h010;
  localparam logic [11:0] OFS_ENABLE_CLEAR = 12'h014;
  localparam logic [11:0] OFS_SOFT_SET = 12'h018;
  localparam logic [11:0] OFS_SOFT_CLEAR = 12'h01c;
  localparam logic [11:0] OFS_VECTOR_ADDR = 12'h030;
  localparam logic [11:0] OFS_DEFAULT_ADDR = 12'h034;
  localparam logic [11:0] OFS_SLOT_STATUS = 12'h038;
  // slot tables: base + 4 * slot
  localparam logic [11:0] OFS_SLOT_ADDR_BASE = 12'h100;
  localparam logic [11:0] OFS_SLOT_CTRL_BASE = 12'h200;
  localparam logic [3:0] PAGE_SLOT_ADDR = 4'h1;
  localparam logic [3:0] PAGE_SLOT_CTRL = 4'h2;

  // slot control word layout
  localparam int SLOT_CH_LSB = 0;
  localparam int SLOT_EN_BIT = 5;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [5:0] RST_SLOT_CTRL = 6'h00;

  // hardware request lines that really exist; the soft-only channel has none
  localparam logic [31:0] HW_LINE_MASK = 32'hffff_fffd;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } vpu_wr_type;

  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
  } vpu_rd_type;

endpackage

// ===== hw/vpu_slot_pick.sv
// fixed-priority pick among the vectored slots, lowest index wins
// assumes hits are already qualified by slot enable and channel activity
`timescale 1ns/1ps
module vpu_slot_pick #(
  parameter int NUM_SLOT = 16,
  parameter int SLOT_W = 4
) (
  input wire logic [NUM_SLOT-1:0] slot_hit,
  output logic any_hit,
  output logic [SLOT_W-1:0] win_slot
);

  always_comb begin
    any_hit = 1'b0;
    win_slot = '0;
    // walk from the top down so slot 0, seen last, overrides all others
    for (int s = NUM_SLOT - 1; s >= 0; s--) begin
      if (slot_hit[s]) begin
        any_hit = 1'b1;
        win_slot = SLOT_W'(s);
      end
    end
  end

endmodule // vpu_slot_pick

// ===== hw/vpu_axil_port.sv
// AXI4-Lite slave front end: turns bus transfers into one-cycle register strobes
// assumes the register file answers a read or write decode in the same cycle, combinationally
`timescale 1ns/1ps
module vpu_axil_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_go,
  output vpu_pkg::vpu_wr_type wr_cmd,
  input wire logic wr_err,
  output logic rd_go,
  output logic [11:0] rd_addr,
  input wire vpu_pkg::vpu_rd_type rd_ans
);

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, rd_go_ff;
  logic aw_full_ff, w_full_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [11:0] rd_addr_ff;
  // the held write fields are split so that each register has a single writer
  logic [11:0] wr_addr_ff;
  logic [31:0] wr_data_ff;
  logic [3:0] wr_strb_ff;
  logic do_write;

  // the write happens once both halves are held and the last response is gone
  assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      awready_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else if (awvalid && awready_ff) begin
      aw_full_ff <= 1'b1;
      awready_ff <= 1'b0;
      wr_addr_ff <= awaddr;
    end else if (do_write) begin
      aw_full_ff <= 1'b0;
    end else if (!aw_full_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_ff <= 1'b0;
      wready_ff <= 1'b0;
      wr_data_ff <= '0;
      wr_strb_ff <= '0;
    end else if (wvalid && wready_ff) begin
      w_full_ff <= 1'b1;
      wready_ff <= 1'b0;
      wr_data_ff <= wdata;
      wr_strb_ff <= wstrb;
    end else if (do_write) begin
      w_full_ff <= 1'b0;
    end else if (!w_full_ff && !bvalid_ff) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= vpu_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_err ? vpu_pkg::RESP_SLVERR : vpu_pkg::RESP_OKAY;
    end else if (bvalid_ff && bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read: accept, decode one cycle later, hold the answer until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rd_go_ff <= 1'b0;
      rd_addr_ff <= '0;
      rvalid_ff <= 1'b0;
      rdata_ff <= vpu_pkg::RST_WORD;
      rresp_ff <= vpu_pkg::RESP_OKAY;
    end else begin
      rd_go_ff <= 1'b0;
      if (arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rd_go_ff <= 1'b1;
        rd_addr_ff <= araddr;
      end else if (rd_go_ff) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_ans.data;
        rresp_ff <= rd_ans.resp;
      end else if (rvalid_ff && rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end else if (!rvalid_ff) begin
        arready_ff <= 1'b1;
      end
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign wr_go = do_write;
  assign wr_cmd = '{addr: wr_addr_ff, data: wr_data_ff, strb: wr_strb_ff};
  assign rd_go = rd_go_ff;
  assign rd_addr = rd_addr_ff;

endmodule // vpu_axil_port

// ===== dv/vpu_monitor.sv
// checker for the vectored priority unit: bus handshake timing and request outputs
// assumes it is bound to vpu_top and sees only its ports
`timescale 1ns/1ps
module vpu_monitor #(
  parameter int NUM_CH = 32,
  parameter int NUM_SLOT = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_CH-1:0] src_request,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fast_request,
  input wire logic normal_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed before handshake");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer not two edges after address");
  a_read_gap: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready [*2])
    else $error("read address taken again too soon");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid && !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write answer not two edges after the write");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid ##1 s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened");
  a_resp_codes: assert property (s_axi_rvalid || s_axi_bvalid
    |-> s_axi_rresp != 2'b01 && s_axi_bresp != 2'b01) else $error("unexpected response code");
  a_fast_cause: assert property ($rose(fast_request)
    |-> $past(|src_request) || $past(|src_request, 2)
    || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("fast request without cause");
  a_normal_cause: assert property ($rose(normal_request)
    |-> $past(|src_request) || $past(|src_request, 2)
    || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("normal request without cause");
  c_fast: cover property ($rose(fast_request));
  c_normal: cover property ($rose(normal_request));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == vpu_pkg::RESP_SLVERR);
endmodule // vpu_monitor

bind vpu_top vpu_monitor #(.NUM_CH(NUM_CH), .NUM_SLOT(NUM_SLOT)) i_mon (
  .aclk(aclk), .aresetn(aresetn),
  .src_request(src_request), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fast_request(fast_request),
  .normal_request(normal_request));

// ===== dv/vpu_core_model.sv
// processor core side: counts entries into fast and normal service
// assumes level requests on aclk; the core itself never answers the unit
`timescale 1ns/1ps
module vpu_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fast_request,
  input wire logic normal_request,
  output int fast_entry_ff,
  output int normal_entry_ff
);
  logic fast_seen_ff;
  logic normal_seen_ff;
  always_ff @(posedge aclk) begin
    fast_seen_ff <= aresetn && fast_request;
    normal_seen_ff <= aresetn && normal_request;
    // a level held high is one entry, not one per cycle
    if (!aresetn) begin
      fast_entry_ff <= 0;
      normal_entry_ff <= 0;
    end else begin
      if (fast_request && !fast_seen_ff) fast_entry_ff <= fast_entry_ff + 1;
      if (normal_request && !normal_seen_ff) normal_entry_ff <= normal_entry_ff + 1;
    end
  end
endmodule // vpu_core_model

// ===== dv/test_vectored_interrupt_priority_unit.sv
// self-checking bench for vpu_top: register calls over AXI4-Lite and request lines
// assumes the monitor is bound in and the core model watches the two request outputs
`timescale 1ns/1ps
module test_vectored_interrupt_priority_unit;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] src_request = 32'h0000_0000;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fast_request, normal_request;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_total = 0;
  int checked = 0;
  int fast_entries, normal_entries;
  localparam int chans[14] = '{0, 4, 5, 6, 7, 8, 11, 13, 14, 15, 16, 17, 18, 21};

  always #2.5 aclk = ~aclk;

  vpu_top i_dut (.aclk(aclk), .aresetn(aresetn), .src_request(src_request),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fast_request(fast_request), .normal_request(normal_request));

  vpu_core_model i_core (.aclk(aclk), .aresetn(aresetn), .fast_request(fast_request),
    .normal_request(normal_request), .fast_entry_ff(fast_entries),
    .normal_entry_ff(normal_entries));

  task summarize;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // no cycle count is assumed: a hung bus is ended by the watchdog
  task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task wrc(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, vpu_pkg::RESP_OKAY});
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk({30'h0, r}, {30'h0, vpu_pkg::RESP_OKAY});
    chk(d, exp);
  endtask

  // three edges: register or line change, output register, then a settled sample
  task set_src(input logic [31:0] v);
    @(posedge aclk);
    src_request <= v;
    repeat (3) @(posedge aclk);
  endtask

  task chk_out(input logic f, input logic n);
    chk({30'h0, fast_request, normal_request}, {30'h0, f, n});
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int e0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdc(vpu_pkg::OFS_CLASS_SELECT, vpu_pkg::RST_WORD);
    rdc(vpu_pkg::OFS_ENABLE_SET, vpu_pkg::RST_WORD);
    rdc(vpu_pkg::OFS_VECTOR_ADDR, vpu_pkg::RST_ADDR);
    chk_out(1'b0, 1'b0);
    wr(12'h040, 32'hffff_ffff, r);
    chk({30'h0, r}, {30'h0, vpu_pkg::RESP_SLVERR});
    rd(12'h040, d, r);
    chk({30'h0, r}, {30'h0, vpu_pkg::RESP_SLVERR});
    chk(d, 32'h0000_0000);
    wrc(vpu_pkg::OFS_ENABLE_SET, 32'hffff_ffff);
    for (int i = 0; i < 14; i++) begin
      set_src(32'h1 << chans[i]);
      chk_out(1'b0, 1'b1);
      rdc(vpu_pkg::OFS_NORMAL_STATUS, 32'h1 << chans[i]);
      set_src(32'h0000_0000);
      chk_out(1'b0, 1'b0);
    end
    set_src(32'h0000_0002);
    rdc(vpu_pkg::OFS_RAW_STATUS, 32'h0000_0000);
    wrc(vpu_pkg::OFS_SOFT_SET, 32'h0000_0002);
    set_src(32'h0000_0000);
    chk_out(1'b0, 1'b1);
    wrc(vpu_pkg::OFS_SOFT_CLEAR, 32'h0000_0002);
    wrc(vpu_pkg::OFS_CLASS_SELECT, 32'h0000_0030);
    e0 = fast_entries;
    set_src(32'h0000_0030);
    chk_out(1'b1, 1'b0);
    rdc(vpu_pkg::OFS_FAST_STATUS, 32'h0000_0030);
    set_src(32'h0000_4030);
    chk_out(1'b1, 1'b1);
    rdc(vpu_pkg::OFS_NORMAL_STATUS, 32'h0000_4000);
    set_src(32'h0000_0020);
    chk_out(1'b1, 1'b0);
    chk(fast_entries - e0, 32'h1);
    set_src(32'h0000_0000);
    chk_out(1'b0, 1'b0);
    wrc(vpu_pkg::OFS_CLASS_SELECT, 32'h0000_0000);
    wrc(vpu_pkg::OFS_DEFAULT_ADDR, 32'h0000_beef);
    for (int s = 0; s < 16; s++) begin
      wrc(vpu_pkg::OFS_SLOT_ADDR_BASE + 12'(4 * s), 32'h0001_0000 + 32'(16 * s));
      wrc(vpu_pkg::OFS_SLOT_CTRL_BASE + 12'(4 * s), 32'h20 | 32'(31 - s));
    end
    set_src(32'hffff_0000);
    rdc(vpu_pkg::OFS_SLOT_STATUS, 32'h0000_ffff);
    wrc(vpu_pkg::OFS_CLASS_SELECT, 32'h8000_0000);
    set_src(32'hffff_0000);
    rdc(vpu_pkg::OFS_VECTOR_ADDR, 32'h0001_0010);
    chk_out(1'b1, 1'b1);
    wrc(vpu_pkg::OFS_CLASS_SELECT, 32'h0000_0000);
    for (int s = 0; s < 16; s++) begin
      rdc(vpu_pkg::OFS_VECTOR_ADDR, 32'h0001_0000 + 32'(16 * s));
      set_src(src_request & ~(32'h1 << (31 - s)));
    end
    rdc(vpu_pkg::OFS_VECTOR_ADDR, 32'h0000_beef);
    chk_out(1'b0, 1'b0);
    wrc(vpu_pkg::OFS_ENABLE_CLEAR, 32'h0000_0001);
    rdc(vpu_pkg::OFS_ENABLE_SET, 32'hffff_fffe);
    set_src(32'h0000_0001);
    chk_out(1'b0, 1'b0);
    rdc(vpu_pkg::OFS_RAW_STATUS, 32'h0000_0001);
    rdc(vpu_pkg::OFS_NORMAL_STATUS, 32'h0000_0000);
    summarize();
  end

  initial begin
    #100000;
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    summarize();
  end
endmodule // test_vectored_interrupt_priority_unit
